// File: rtl/tthc_pkg.sv
/*
 thermal throttle control package: register offsets, field positions, reset values, timing constants.
 assumes a 32-bit axi4-lite register bus and two cores.
*/
`default_nettype none
package tthc_pkg;
	localparam int unsigned NUM_CORES     = 2;
	localparam int unsigned TEMP_W        = 7;
	// register byte offsets
	localparam logic [7:0] OFS_ODM_CTRL   = 8'h00;
	localparam logic [7:0] OFS_AUTO_CTRL  = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h08;
	localparam logic [7:0] OFS_SENSE0     = 8'h0c;
	localparam logic [7:0] OFS_SENSE1     = 8'h10;
	localparam logic [7:0] OFS_THRESH0    = 8'h14;
	localparam logic [7:0] OFS_THRESH1    = 8'h18;
	localparam logic [7:0] OFS_PSTATE     = 8'h1c;
	localparam logic [7:0] OFS_INT_STAT   = 8'h20;
	// on-demand control fields
	localparam int unsigned ODM_EN_BIT    = 4;
	localparam int unsigned ODM_DUTY_LSB  = 1;
	localparam int unsigned ODM_DUTY_W    = 3;
	// auto control fields
	localparam int unsigned AUTO_CLKMOD_BIT = 0;
	localparam int unsigned AUTO_PSTATE_BIT = 1;
	localparam int unsigned ALERT_IRQ_RISE  = 2;
	localparam int unsigned ALERT_IRQ_FALL  = 3;
	// sensor register fields
	localparam int unsigned SENSE_FAULT_BIT  = 8;
	localparam int unsigned SENSE_STICKY_BIT = 9;
	localparam int unsigned SENSE_VALID_BIT  = 31;
	// thresholds: lower byte threshold a, next byte threshold b
	localparam int unsigned THR_B_LSB     = 8;
	localparam int unsigned PST_W         = 4;
	// hysteresis below the trip point, in sensor units
	localparam logic [6:0] HYST_DEG       = 7'h02;
	// modulation period: eight slots of fixed length
	localparam int unsigned SLOT_NS       = 64;
	localparam int unsigned CLK_NS        = 8;
	localparam int unsigned SLOT_CYC      = SLOT_NS / CLK_NS;
	localparam logic [2:0]  AUTO_DUTY     = 3'h4;
	localparam logic [31:0] ODM_RESET     = 32'h0000_0000;
	localparam logic [31:0] AUTO_RESET    = 32'h0000_0003;
	localparam logic [3:0]  PST_RESET     = 4'h0;
endpackage
`default_nettype wire

// File: rtl/tthc_top.sv
/*
 thermal throttle control: trip detection, clock modulation, p-state throttling, alert and
 catastrophic trip pins, per-core digital readout with thresholds, axi4-lite register slave.
 assumes per-core sensor readings arrive as degrees below tj,max, synchronous to aclk.
*/
// Behaviour
// - trip point fixed in hardware, not configurable
// - interrupts latched, serviced while clocks run
// - automatic request beats on-demand request
// - auto mode activates only at maximum temperature or external alert
// - pstate mode lowers point, restores when cool
// - pstate first, clock modulation if still hot
// - higher software target deferred during throttle
// - lower software target applied at once
// - modulate clocks while hot, stop when cool
// - hysteresis keeps circuit from toggling
// - auto duty fixed at half on
// - on-demand bit with nonzero duty activates circuit regardless
// - on-demand duty from three-bit field
// - alert pin low above trip point
// - alert interrupt on rise, fall or both
// - no new alert in low-power states
// - catastrophic trip shuts modes, drives trip pin
// - per-core reading valid only in full run
// - reading relative to maximum, never above
// - fault bit shares register with reading
// - throttle engages when reading hits maximum
// - two thresholds per core raise interrupts
// - external alert drive throttles both cores
// - clock-mod per hot core, pstate both cores
// - still hot after throttle latches fault, sticky
`timescale 1ns/1ps
`default_nettype none
module tthc_top
	import tthc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// sensors: degrees below tj,max per core; zero means at maximum
	input  wire logic [6:0]  die_temp_sensor_c0,
	input  wire logic [6:0]  die_temp_sensor_c1,
	input  wire logic [1:0]  sensor_overrange,
	input  wire logic        cat_temp_reached,
	input  wire logic [1:0]  full_run_power_state,
	input  wire logic        low_power_state,
	// alert pin, open drain
	input  wire logic        overtemp_alert_n_in,
	output logic             overtemp_alert_n_out,
	output logic             overtemp_alert_n_oe,
	output logic             catastrophic_trip_n,
	// core control
	output logic [1:0]       core_clk_en,
	output logic [3:0]       pstate_out,
	output logic [1:0]       core_local_interrupt_ctrl
);
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	logic [31:0] odm_ctrl_ff;
	logic [31:0] auto_ctrl_ff;
	logic [15:0] thresh_ff [NUM_CORES];
	logic [3:0]  sw_pstate_ff;
	logic [3:0]  therm_pstate_ff;
	logic [3:0]  pstate_ff;
	logic [1:0]  hot_ff;
	logic        cat_ff;
	logic [1:0]  fault_ff;
	logic [1:0]  sticky_ff;
	logic [1:0]  pst_dwell_ff;
	logic [2:0]  slot_ff;
	logic [3:0]  slot_cnt_ff;
	logic        alert_drv_ff;
	logic        alert_seen_ff;
	logic [1:0]  clk_en_ff;
	logic [5:0]  irq_ff;
	logic [1:0]  irq_out_ff;
	logic [1:0]  thr_a_below_ff;
	logic [1:0]  thr_b_below_ff;

	logic        aw_hold_ff;
	logic        w_hold_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	wire [6:0] rel [NUM_CORES];
	assign rel[0] = die_temp_sensor_c0;
	assign rel[1] = die_temp_sensor_c1;

	// trip with hysteresis per core; trip point is reading zero, no register reaches it
	wire [1:0] at_max;
	wire [1:0] cooled;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CORES; gi++)
		begin : g_core
			assign at_max[gi] = (rel[gi] == 7'h00);
			assign cooled[gi] = (rel[gi] >= HYST_DEG);
		end
	endgenerate
	wire [1:0] nxt_hot = (hot_ff | at_max) & ~cooled;

	wire ext_alert    = ~overtemp_alert_n_in & ~alert_drv_ff;
	wire auto_clkmod  = auto_ctrl_ff[AUTO_CLKMOD_BIT];
	wire auto_pstate  = auto_ctrl_ff[AUTO_PSTATE_BIT];
	wire any_hot      = |hot_ff;
	wire auto_en      = auto_clkmod | auto_pstate;
	// auto trigger only at maximum temperature or external alert
	wire auto_trig    = auto_en & (any_hot | ext_alert);
	wire pst_active   = auto_pstate & (any_hot | ext_alert);
	// clock modulation after pstate has had its dwell, or alone
	wire pst_done     = ~auto_pstate | (pst_dwell_ff == 2'h3);
	wire [1:0] cm_hot = (hot_ff | {2{ext_alert}}) & {2{auto_clkmod & pst_done}};
	wire odm_en       = odm_ctrl_ff[ODM_EN_BIT];
	wire [2:0] odm_duty = odm_ctrl_ff[ODM_DUTY_LSB +: ODM_DUTY_W];
	// automatic wins with its fixed half duty
	wire [2:0] duty   = (|cm_hot) ? AUTO_DUTY : odm_duty;
	wire [1:0] mod_on = cat_ff ? 2'b00 : ((|cm_hot) ? cm_hot : {2{odm_en & (odm_duty != 3'h0)}});
	wire       run_slot = (slot_ff < duty);
	wire [1:0] nxt_clk_en = cat_ff ? 2'b00 : (~mod_on | {2{run_slot}});
	wire       slot_tick = (slot_cnt_ff == 4'(SLOT_CYC - 1));
	wire       still_hot = auto_trig & pst_done;

	// pstate arbitration
	wire [3:0] pst_target = (sw_pstate_ff > therm_pstate_ff) ? sw_pstate_ff : therm_pstate_ff;
	wire [3:0] nxt_pstate = cat_ff ? pstate_ff : (pst_active ? pst_target : sw_pstate_ff);

	// alert pin: no new assertion in low power
	wire alert_cond = |hot_ff;
	wire nxt_alert  = low_power_state ? alert_drv_ff : alert_cond;
	wire alert_pin  = ~overtemp_alert_n_in;
	wire alert_rise = alert_pin & ~alert_seen_ff;
	wire alert_fall = ~alert_pin & alert_seen_ff;

	// bus decode
	wire aw_ok = aw_hold_ff | s_axi_awvalid;
	wire w_ok  = w_hold_ff | s_axi_wvalid;
	wire [7:0]  wa = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
	wire [31:0] wd = w_hold_ff ? wdata_ff : s_axi_wdata;
	wire [3:0]  ws = w_hold_ff ? wstrb_ff : s_axi_wstrb;
	wire do_wr = aw_ok & w_ok & ~bvalid_ff;
	wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
	wire wr_odm  = do_wr & (wa == OFS_ODM_CTRL);
	wire wr_auto = do_wr & (wa == OFS_AUTO_CTRL);
	wire wr_th0  = do_wr & (wa == OFS_THRESH0);
	wire wr_th1  = do_wr & (wa == OFS_THRESH1);
	wire wr_pst  = do_wr & (wa == OFS_PSTATE);
	wire wr_int  = do_wr & (wa == OFS_INT_STAT);
	wire wr_hit  = wr_odm | wr_auto | wr_th0 | wr_th1 | wr_pst | wr_int | (wa == OFS_STATUS)
		| (wa == OFS_SENSE0) | (wa == OFS_SENSE1);
	wire do_rd = s_axi_arvalid & ~rvalid_ff;

	// sensor readout: zeroed outside full run
	wire [31:0] sense_word [NUM_CORES];
	generate
		for (gi = 0; gi < NUM_CORES; gi++)
		begin : g_sense
			assign sense_word[gi] = full_run_power_state[gi]
				? {1'b1, 21'h0, sticky_ff[gi], fault_ff[gi], 1'b0, rel[gi]}
				: 32'h0000_0000;
		end
	endgenerate
	wire [31:0] status_word = {20'h0, pstate_ff, 1'b0, cat_ff, ext_alert, alert_drv_ff, clk_en_ff, hot_ff};
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_ODM_CTRL:  rd_mux = odm_ctrl_ff;
			OFS_AUTO_CTRL: rd_mux = auto_ctrl_ff;
			OFS_STATUS:    rd_mux = status_word;
			OFS_SENSE0:    rd_mux = sense_word[0];
			OFS_SENSE1:    rd_mux = sense_word[1];
			OFS_THRESH0:   rd_mux = {16'h0, thresh_ff[0]};
			OFS_THRESH1:   rd_mux = {16'h0, thresh_ff[1]};
			OFS_PSTATE:    rd_mux = {20'h0, therm_pstate_ff, 4'h0, sw_pstate_ff};
			OFS_INT_STAT:  rd_mux = {26'h0, irq_ff};
			default:
			begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// threshold crossings: bit set means reading is below threshold (cooler)
	wire [1:0] nxt_a_below;
	wire [1:0] nxt_b_below;
	generate
		for (gi = 0; gi < NUM_CORES; gi++)
		begin : g_thr
			assign nxt_a_below[gi] = rel[gi] > thresh_ff[gi][6:0];
			assign nxt_b_below[gi] = rel[gi] > thresh_ff[gi][THR_B_LSB +: 7];
		end
	endgenerate
	wire [1:0] thr_cross = full_run_power_state
		& ((nxt_a_below ^ thr_a_below_ff) | (nxt_b_below ^ thr_b_below_ff));
	wire [5:0] irq_set = {thr_cross,
		(|(fault_ff & ~sticky_ff)),
		1'b0,
		alert_fall & auto_ctrl_ff[ALERT_IRQ_FALL],
		alert_rise & auto_ctrl_ff[ALERT_IRQ_RISE]};
	wire [5:0] irq_clr = wr_int ? wd[5:0] : 6'h00;
	wire [5:0] nxt_irq = irq_set | (irq_ff & ~irq_clr);
	// interrupt lines stay latched, delivered only while that core's clock runs
	wire [1:0] core_irq_pend = {irq_ff[5] | irq_ff[3] | (|irq_ff[1:0]), irq_ff[4] | irq_ff[3] | (|irq_ff[1:0])};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			odm_ctrl_ff     <= ODM_RESET;
			auto_ctrl_ff    <= AUTO_RESET;
			thresh_ff[0]    <= 16'h0000;
			thresh_ff[1]    <= 16'h0000;
			sw_pstate_ff    <= PST_RESET;
			therm_pstate_ff <= 4'hf;
		end
		else
		begin
			if (wr_odm)
				odm_ctrl_ff <= (odm_ctrl_ff & ~wmask) | (wd & wmask & 32'h0000_001e);
			if (wr_auto)
				auto_ctrl_ff <= (auto_ctrl_ff & ~wmask) | (wd & wmask & 32'h0000_000f);
			if (wr_th0)
				thresh_ff[0] <= (thresh_ff[0] & ~wmask[15:0]) | (wd[15:0] & wmask[15:0]);
			if (wr_th1)
				thresh_ff[1] <= (thresh_ff[1] & ~wmask[15:0]) | (wd[15:0] & wmask[15:0]);
			if (wr_pst & ws[0])
				sw_pstate_ff <= wd[3:0];
			if (wr_pst & ws[1])
				therm_pstate_ff <= wd[11:8];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hot_ff         <= 2'b00;
			cat_ff         <= 1'b0;
			fault_ff       <= 2'b00;
			sticky_ff      <= 2'b00;
			pst_dwell_ff   <= 2'h0;
			slot_ff        <= 3'h0;
			slot_cnt_ff    <= 4'h0;
			pstate_ff      <= PST_RESET;
			clk_en_ff      <= 2'b11;
			alert_drv_ff   <= 1'b0;
			alert_seen_ff  <= 1'b0;
			irq_ff         <= 6'h00;
			irq_out_ff     <= 2'b00;
			thr_a_below_ff <= 2'b11;
			thr_b_below_ff <= 2'b11;
		end
		else
		begin
			hot_ff         <= nxt_hot;
			cat_ff         <= cat_ff | cat_temp_reached;
			fault_ff       <= sensor_overrange | ({2{still_hot}} & hot_ff);
			sticky_ff      <= sticky_ff | fault_ff;
			pst_dwell_ff   <= pst_active ? (pst_dwell_ff + {1'b0, slot_tick & (pst_dwell_ff != 2'h3)}) : 2'h0;
			slot_cnt_ff    <= slot_tick ? 4'h0 : slot_cnt_ff + 4'h1;
			if (slot_tick)
				slot_ff <= slot_ff + 3'h1;
			pstate_ff      <= nxt_pstate;
			clk_en_ff      <= nxt_clk_en;
			alert_drv_ff   <= nxt_alert & ~cat_ff;
			alert_seen_ff  <= alert_pin;
			irq_ff         <= nxt_irq;
			irq_out_ff     <= core_irq_pend & clk_en_ff;
			thr_a_below_ff <= nxt_a_below;
			thr_b_below_ff <= nxt_b_below;
		end
	end

	// axi4-lite handshakes: address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OK;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OK;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready & ~do_wr)
			begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			else if (do_wr)
				aw_hold_ff <= 1'b0;
			if (s_axi_wvalid & s_axi_wready & ~do_wr)
			begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			else if (do_wr)
				w_hold_ff <= 1'b0;
			if (do_wr)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'b0;
			if (do_rd)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_mux;
				rresp_ff  <= rd_hit ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	// ready is high whenever that channel's holding slot is free and no response waits
	assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	assign overtemp_alert_n_out      = 1'b0;
	assign overtemp_alert_n_oe       = alert_drv_ff;
	assign catastrophic_trip_n       = ~cat_ff;
	assign core_clk_en               = clk_en_ff;
	assign pstate_out                = pstate_ff;
	assign core_local_interrupt_ctrl = irq_out_ff;
endmodule
`default_nettype wire

// File: test/tthc_chk_sva.sv
/*
 concurrent checks on the tthc_top ports.
 assumes the bench keeps one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tthc_chk
(
	// clock and reset
	input	wire logic		aclk,
	input	wire logic		aresetn,
	// bus handshakes
	input	wire logic		s_axi_awready,
	input	wire logic [1:0]	s_axi_bresp,
	input	wire logic		s_axi_bvalid,
	input	wire logic		s_axi_bready,
	input	wire logic [31:0]	s_axi_rdata,
	input	wire logic		s_axi_rvalid,
	input	wire logic		s_axi_rready,
	// thermal side
	input	wire logic [6:0]	die_temp_sensor_c0,
	input	wire logic [6:0]	die_temp_sensor_c1,
	input	wire logic		cat_temp_reached,
	input	wire logic [1:0]	full_run_power_state,
	input	wire logic		low_power_state,
	input	wire logic		overtemp_alert_n_oe,
	input	wire logic		catastrophic_trip_n,
	input	wire logic [1:0]	core_clk_en,
	input	wire logic [3:0]	pstate_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0]	off_cnt_ff;
	logic [7:0]	nxt_off_cnt;
	// a tripped part may park its clocks, so the run length restarts there
	assign nxt_off_cnt = (core_clk_en[0] || !catastrophic_trip_n) ? 8'h00 : off_cnt_ff + 8'h01;
	always_ff @(posedge aclk)
	begin
		off_cnt_ff <= aresetn ? nxt_off_cnt : 8'h00;
	end
	// four edges cover the two-edge output lag
	sequence s_hot;
		(die_temp_sensor_c0 == 7'h00 && !low_power_state && full_run_power_state == 2'b11 && catastrophic_trip_n)[*4];
	endsequence
	sequence s_cool;
		(die_temp_sensor_c0 >= 7'h02 && die_temp_sensor_c1 >= 7'h02 && !low_power_state)[*4];
	endsequence
	sequence s_sleep;
		low_power_state[*3];
	endsequence
	chk_trip_held: assert property (!catastrophic_trip_n |=> !catastrophic_trip_n)
		else $error("trip pin released");
	chk_trip_cat: assert property (cat_temp_reached |-> ##[1:3] !catastrophic_trip_n)
		else $error("no trip on catastrophic heat");
	chk_alert_hot: assert property (s_hot |-> overtemp_alert_n_oe)
		else $error("alert not driven while hot");
	chk_alert_cool: assert property (s_cool |-> !overtemp_alert_n_oe)
		else $error("alert driven while cool");
	chk_sleep_quiet: assert property (s_sleep ##0 !overtemp_alert_n_oe |=> !overtemp_alert_n_oe)
		else $error("alert raised in low power");
	chk_duty_bound: assert property (off_cnt_ff <= 8'h38)
		else $error("clock stopped longer than seven slots");
	chk_reset_vals: assert property (!$past(aresetn) |-> core_clk_en == 2'b11 && pstate_out == 4'h0 && catastrophic_trip_n)
		else $error("bad outputs after reset");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken while response waits");
endmodule
bind tthc_top tthc_chk chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .die_temp_sensor_c0, .die_temp_sensor_c1, .cat_temp_reached,
	.full_run_power_state, .low_power_state, .overtemp_alert_n_oe, .catastrophic_trip_n, .core_clk_en, .pstate_out);
`default_nettype wire

// File: test/tthc_sys_model.sv
/*
 system side of the alert pin: pull-up plus an external agent that may pull it low.
 assumes pull_req changes just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tthc_sys_model
(
	// clock
	input	wire logic	aclk,
	// pin parties
	input	wire logic	pull_req,
	input	wire logic	alert_oe,
	output	logic		alert_level
);
	logic	pull_ff = 1'b0;
	always_ff @(posedge aclk)
	begin
		pull_ff <= pull_req;
	end
	// open drain: either party pulls low, the pull-up wins otherwise
	assign alert_level = !(alert_oe || pull_ff);
endmodule
`default_nettype wire

// File: test/tthc_top_tb.sv
/*
 self-checking bench for tthc_top: bus tasks, thermal scenarios, random traffic.
 assumes the sys model resolves the alert pin and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module tthc_top_tb;
	import tthc_pkg::*;
	logic		aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic		s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0]	s_axi_wdata = '0, s_axi_rdata, rd, n0, n1, d;
	logic [3:0]	s_axi_wstrb = 4'hf, pstate_out;
	logic [1:0]	s_axi_bresp, s_axi_rresp, rs, core_clk_en, core_local_interrupt_ctrl;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [6:0]	die_temp_sensor_c0 = 7'h10, die_temp_sensor_c1 = 7'h10;
	logic [1:0]	full_run_power_state = 2'b11, sensor_overrange = 2'b00;
	logic		cat_temp_reached = 0, low_power_state = 0, pull = 0;
	logic		overtemp_alert_n_in, overtemp_alert_n_out, overtemp_alert_n_oe, catastrophic_trip_n;
	int		seed = 47, fails = 0, total_checks = 0, cyc = 0;
	tthc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .die_temp_sensor_c0,
		.die_temp_sensor_c1, .sensor_overrange, .cat_temp_reached, .full_run_power_state, .low_power_state,
		.overtemp_alert_n_in, .overtemp_alert_n_out, .overtemp_alert_n_oe, .catastrophic_trip_n, .core_clk_en,
		.pstate_out, .core_local_interrupt_ctrl);
	tthc_sys_model sys_u (.aclk(aclk), .pull_req(pull), .alert_oe(overtemp_alert_n_oe),
		.alert_level(overtemp_alert_n_in));
	always #4 aclk = ~aclk;
	task automatic close_out();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// readies are looked at mid-cycle, where they equal what the next edge samples
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, dn;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			dn = s_axi_bvalid && s_axi_bready;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (dn) s_axi_bready <= 1'b0;
		end while (!dn);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		logic ta, dn;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			dn = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (dn) s_axi_rready <= 1'b0;
		end while (!dn);
	endtask
	// one full modulation period counted after the lag and any dwell
	task automatic run_cnt();
		repeat (80) @(posedge aclk);
		n0 = 0;
		n1 = 0;
		repeat (64)
		begin
			@(negedge aclk);
			n0 = n0 + core_clk_en[0];
			n1 = n1 + core_clk_en[1];
		end
	endtask
	function automatic logic [31:0] on_exp(input logic [2:0] n);
		return (n == 3'h0) ? 32'h40 : {26'h0, n, 3'h0};
	endfunction
	function automatic logic [31:0] thr_exp(input logic [31:0] v);
		return v & 32'h0000_ffff;
	endfunction
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(OFS_AUTO_CTRL);
		chk_w(rd, AUTO_RESET, "auto reset");
		rd_reg(OFS_PSTATE);
		chk_w(rd, 32'h0000_0f00, "pstate reset");
		rd_reg(8'h40);
		chk_w({rd[29:0], rs}, 32'h2, "unmapped read");
		wr(8'h40, 32'hffff_ffff);
		chk_w({30'h0, rs}, 32'h2, "unmapped write");
		for (int i = 0; i < 6; i++)
		begin
			d = $random(seed);
			die_temp_sensor_c0 <= 7'h02 + 7'(d[29:24] & 6'h3f);
			wr(OFS_THRESH0, d);
			rd_reg(OFS_THRESH0);
			chk_w(rd, thr_exp(d), "threshold");
			chk_w({31'h0, overtemp_alert_n_oe}, 32'h0, "cool alert");
		end
		rd_reg(OFS_SENSE0);
		chk_w(rd, 32'h8000_0000 | die_temp_sensor_c0, "reading");
		full_run_power_state <= 2'b10;
		repeat (4) @(posedge aclk);
		rd_reg(OFS_SENSE0);
		chk_w(rd, 32'h0, "reading out of run");
		full_run_power_state <= 2'b11;
		sensor_overrange <= 2'b01;
		repeat (4) @(posedge aclk);
		rd_reg(OFS_SENSE0);
		chk_w(rd, 32'h8000_0300 | die_temp_sensor_c0, "fault and sticky");
		chk_w({30'h0, core_local_interrupt_ctrl}, 32'h3, "fault irq lines");
		sensor_overrange <= 2'b00;
		wr(OFS_INT_STAT, 32'h3f);
		repeat (2) @(posedge aclk);
		chk_w({30'h0, core_local_interrupt_ctrl}, 32'h0, "irq lines cleared");
		for (int n = 0; n < 8; n++)
		begin
			wr(OFS_ODM_CTRL, 32'h10 | (n << 1));
			run_cnt();
			chk_w(n0, on_exp(3'(n)), "demand duty");
		end
		wr(OFS_ODM_CTRL, 32'h0);
		wr(OFS_AUTO_CTRL, 32'hd);
		die_temp_sensor_c0 <= 7'h00;
		run_cnt();
		chk_w(n0, 32'h20, "auto duty");
		chk_w(n1, 32'h40, "cool core runs");
		chk_w({31'h0, overtemp_alert_n_oe}, 32'h1, "hot alert");
		rd_reg(OFS_INT_STAT);
		chk_w(rd & 32'h1, 32'h1, "alert rise irq");
		wr(OFS_ODM_CTRL, 32'h12);
		die_temp_sensor_c0 <= 7'h01;
		run_cnt();
		chk_w(n0, 32'h20, "auto beats demand");
		wr(OFS_ODM_CTRL, 32'h0);
		die_temp_sensor_c0 <= 7'h05;
		run_cnt();
		chk_w(n0, 32'h40, "modulation stops");
		rd_reg(OFS_INT_STAT);
		chk_w(rd & 32'h2, 32'h2, "alert fall irq");
		wr(OFS_AUTO_CTRL, 32'h2);
		wr(OFS_PSTATE, 32'h0803);
		die_temp_sensor_c1 <= 7'h00;
		run_cnt();
		chk_w({28'h0, pstate_out}, 32'h8, "thermal pstate");
		wr(OFS_PSTATE, 32'h0802);
		repeat (8) @(posedge aclk);
		chk_w({28'h0, pstate_out}, 32'h8, "faster deferred");
		wr(OFS_PSTATE, 32'h080a);
		repeat (8) @(posedge aclk);
		chk_w({28'h0, pstate_out}, 32'ha, "slower applied");
		wr(OFS_AUTO_CTRL, 32'h3);
		die_temp_sensor_c0 <= 7'h00;
		run_cnt();
		chk_w(n0, 32'h20, "both modes still hot");
		wr(OFS_PSTATE, 32'h0802);
		die_temp_sensor_c0 <= 7'h05;
		die_temp_sensor_c1 <= 7'h05;
		repeat (20) @(posedge aclk);
		chk_w({28'h0, pstate_out}, 32'h2, "pstate restored");
		wr(OFS_AUTO_CTRL, 32'h1);
		pull <= 1'b1;
		run_cnt();
		chk_w(n0 + n1, 32'h40, "external alert");
		@(posedge aclk);
		pull <= 1'b0;
		low_power_state <= 1'b1;
		repeat (4) @(posedge aclk);
		die_temp_sensor_c0 <= 7'h00;
		repeat (8) @(posedge aclk);
		chk_w({31'h0, overtemp_alert_n_oe}, 32'h0, "low power alert");
		die_temp_sensor_c0 <= 7'h05;
		low_power_state <= 1'b0;
		cat_temp_reached <= 1'b1;
		repeat (4) @(posedge aclk);
		chk_w({31'h0, catastrophic_trip_n}, 32'h0, "trip");
		cat_temp_reached <= 1'b0;
		repeat (20) @(posedge aclk);
		chk_w({31'h0, catastrophic_trip_n}, 32'h0, "trip held");
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_w({31'h0, catastrophic_trip_n}, 32'h1, "trip cleared by reset");
		close_out();
	end
endmodule
`default_nettype wire
